// [verilog/branch2_exec.sv]
// execution sequencer for compare, loop, trap, frame and return instructions
`timescale 1ns/1ps
`include "branch2_cfg.svh"

module branch2_exec (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // issue from decode
  input  wire logic              issueValid,
  output logic                   issueReady,
  input  wire branch2_pkg::issue_t issueData,
  input  wire logic [3:0]        flagsIn,
  // stack words read by the core's stack unit
  input  wire logic [15:0]       stackWord0,
  input  wire logic [15:0]       stackWord1,
  input  wire logic [15:0]       framePtr,
  input  wire logic [15:0]       stackPtr,
  // completion to the core
  output logic                   doneValid,
  output branch2_pkg::done_t     doneData,
  output logic                   busy,
  output logic [2:0]             stackWords
);

  // ===========================================================
  // operand arithmetic
  branch2_pkg::issue_t issueReg;
  branch2_pkg::state_t stateReg;
  branch2_pkg::state_t stateNext;
  // nine bits so that the largest addressing overhead cannot wrap
  logic [8:0]          countReg;
  logic [8:0]          countNext;
  logic [8:0]          cycleTotal;
  logic [15:0]         cmpDiff;
  logic [15:0]         decValue;
  logic [15:0]         target;
  logic                cmpUnequal;
  logic                cmpCarry;
  logic                cmpOvf;
  logic                decNonzero;
  logic                decOvf;
  logic                isCompare;
  logic                isDecrement;
  logic                taken;
  logic [3:0]          cmpFlags;
  logic [3:0]          decFlags;
  branch2_pkg::done_t  doneNext;
  branch2_pkg::done_t  doneReg;
  logic                doneValidReg;
  logic [16:0]         cmpWide;

  wire branch2_pkg::op_t opCode = issueReg.op;

  // byte forms compare only the low bytes; post-increment forms
  // never reach here, so no operand side effect is modelled
  assign cmpWide = issueReg.isWord
    ? {1'b0, issueReg.operand} - {1'b0, issueReg.immediate}
    : {9'h000, issueReg.operand[7:0]} - {9'h000, issueReg.immediate[7:0]};
  assign cmpDiff  = cmpWide[15:0];
  assign cmpCarry = issueReg.isWord ? cmpWide[16] : cmpWide[8];
  assign cmpOvf   = issueReg.isWord
    ? (issueReg.operand[15] ^ issueReg.immediate[15]) &
      (issueReg.operand[15] ^ cmpDiff[15])
    : (issueReg.operand[7] ^ issueReg.immediate[7]) &
      (issueReg.operand[7] ^ cmpDiff[7]);
  assign cmpUnequal = issueReg.isWord ? (cmpDiff != 16'h0000)
                                      : (cmpDiff[7:0] != 8'h00);
  assign cmpFlags = {issueReg.isWord ? cmpDiff[15] : cmpDiff[7],
                     ~cmpUnequal, cmpOvf, cmpCarry};

  assign decValue = issueReg.isWord ? issueReg.operand - 16'h0001
    : {8'h00, issueReg.operand[7:0] - 8'h01};
  assign decNonzero = (decValue != 16'h0000);
  assign decOvf = issueReg.isWord ? (issueReg.operand == 16'h8000)
                                  : (issueReg.operand[7:0] == 8'h80);
  // carry is kept from the incoming flags
  assign decFlags = {issueReg.isWord ? decValue[15] : decValue[7],
                     ~decNonzero, decOvf, flagsIn[`FLAG_C]};

  assign isCompare = (opCode == branch2_pkg::OP_CMP_ACC) |
                     (opCode == branch2_pkg::OP_CMP_REG) |
                     (opCode == branch2_pkg::OP_CMP_MEM);
  assign isDecrement = (opCode == branch2_pkg::OP_DEC_REG) |
                       (opCode == branch2_pkg::OP_DEC_MEM);
  assign taken = (isCompare & cmpUnequal) | (isDecrement & decNonzero);

  // next instruction plus sign-extended displacement
  assign target = issueReg.nextPc + {{8{issueReg.disp[7]}}, issueReg.disp};

  // ===========================================================
  // cycle budget per form
  always_comb begin
    cycleTotal = 9'h001;
    case (opCode)
      branch2_pkg::OP_CMP_ACC:
        cycleTotal = taken ? `CYC_CBA_TAKEN : `CYC_CBA_NOT;
      branch2_pkg::OP_CMP_REG:
        if (issueReg.isWord) begin
          cycleTotal = taken ? `CYC_CWR_TAKEN : `CYC_CWR_NOT;
        end else begin
          cycleTotal = taken ? `CYC_CBR_TAKEN : `CYC_CBR_NOT;
        end
      branch2_pkg::OP_CMP_MEM:
        cycleTotal = (taken ? `CYC_CBM_TAKEN : `CYC_CBM_NOT)
                     + {1'b0, issueReg.addrCycles};
      branch2_pkg::OP_DEC_REG:
        cycleTotal = taken ? `CYC_DBR_TAKEN : `CYC_DBR_NOT;
      branch2_pkg::OP_DEC_MEM:
        cycleTotal = (taken ? `CYC_DBM_TAKEN : `CYC_DBM_NOT)
                     + {1'b0, issueReg.addrCycles};
      branch2_pkg::OP_TRAP_VEC:   cycleTotal = `CYC_TRAP_VEC;
      branch2_pkg::OP_TRAP_A16:   cycleTotal = `CYC_TRAP_A16;
      branch2_pkg::OP_TRAP_A24:   cycleTotal = `CYC_TRAP_A24;
      branch2_pkg::OP_TRAP_SHORT: cycleTotal = `CYC_TRAP_SHORT;
      branch2_pkg::OP_TRAP_RET:   cycleTotal = `CYC_TRAP_RET;
      branch2_pkg::OP_FRAME_SET:  cycleTotal = `CYC_FRAME_SET;
      branch2_pkg::OP_FRAME_DOWN: cycleTotal = `CYC_FRAME_DOWN;
      branch2_pkg::OP_RET_NEAR:   cycleTotal = `CYC_RET_NEAR;
      branch2_pkg::OP_RET_FAR:    cycleTotal = `CYC_RET_FAR;
      default:                    cycleTotal = 9'h001;
    endcase
  end

  // ===========================================================
  // completion record
  always_comb begin
    doneNext = '0;
    doneNext.pc = issueReg.nextPc;
    doneNext.busLock = (opCode == branch2_pkg::OP_DEC_MEM);
    case (opCode)
      branch2_pkg::OP_CMP_ACC, branch2_pkg::OP_CMP_REG,
      branch2_pkg::OP_CMP_MEM: begin
        doneNext.flags     = cmpFlags;
        doneNext.flagsLoad = 1'b1;
        doneNext.pc        = taken ? target : issueReg.nextPc;
        doneNext.pcLoad    = 1'b1;
      end
      branch2_pkg::OP_DEC_REG, branch2_pkg::OP_DEC_MEM: begin
        doneNext.flags       = decFlags;
        doneNext.flagsLoad   = 1'b1;
        doneNext.result      = decValue;
        doneNext.resultWrite = 1'b1;
        doneNext.pc          = taken ? target : issueReg.nextPc;
        doneNext.pcLoad      = 1'b1;
      end
      branch2_pkg::OP_TRAP_VEC, branch2_pkg::OP_TRAP_A16,
      branch2_pkg::OP_TRAP_A24, branch2_pkg::OP_TRAP_SHORT: begin
        doneNext.pc       = issueReg.trapPc;
        doneNext.pcLoad   = 1'b1;
        doneNext.bank     = issueReg.trapBank;
        doneNext.bankLoad = 1'b1;
      end
      branch2_pkg::OP_TRAP_RET: begin
        // program counter and bank come from the unstacked words
        doneNext.pc        = stackWord0;
        doneNext.bank      = stackWord1[7:0];
        doneNext.pcLoad    = 1'b1;
        doneNext.bankLoad  = 1'b1;
        doneNext.flags     = stackWord1[11:8];
        doneNext.flagsLoad = 1'b1;
      end
      branch2_pkg::OP_FRAME_SET: begin
        // new frame pointer is the stack after the push
        doneNext.frameSp   = stackPtr - {8'h00, issueReg.immediate[7:0]};
        doneNext.result    = stackPtr;
        doneNext.frameLoad = 1'b1;
      end
      branch2_pkg::OP_FRAME_DOWN: begin
        doneNext.result    = stackWord0;
        doneNext.frameSp   = framePtr;
        doneNext.frameLoad = 1'b1;
      end
      branch2_pkg::OP_RET_NEAR: begin
        doneNext.pc     = stackWord0;
        doneNext.pcLoad = 1'b1;
      end
      branch2_pkg::OP_RET_FAR: begin
        doneNext.pc       = stackWord0;
        doneNext.bank     = stackWord1[7:0];
        doneNext.pcLoad   = 1'b1;
        doneNext.bankLoad = 1'b1;
      end
      default: doneNext.pcLoad = 1'b0;
    endcase
  end

  // ===========================================================
  // sequencer
  assign issueReady = (stateReg == branch2_pkg::ST_IDLE);
  assign busy       = (stateReg != branch2_pkg::ST_IDLE);
  assign stackWords = (opCode == branch2_pkg::OP_TRAP_RET)
                      ? `TRAP_RET_WORDS : 3'h0;
  assign doneValid  = doneValidReg;
  assign doneData   = doneReg;

  always_comb begin
    stateNext = stateReg;
    countNext = countReg;
    case (stateReg)
      branch2_pkg::ST_IDLE:
        if (issueValid) begin
          stateNext = branch2_pkg::ST_RUN;
          countNext = 9'h001;
        end
      branch2_pkg::ST_RUN:
        // done pulses on the last cycle of the budget
        if (countReg + 9'h001 >= cycleTotal) begin
          stateNext = branch2_pkg::ST_DONE;
        end else begin
          countNext = countReg + 9'h001;
        end
      branch2_pkg::ST_DONE: stateNext = branch2_pkg::ST_IDLE;
      default:              stateNext = branch2_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stateReg     <= branch2_pkg::ST_IDLE;
      countReg     <= 9'h000;
      issueReg     <= '0;
      doneReg      <= '0;
      doneValidReg <= 1'b0;
    end else begin
      stateReg     <= stateNext;
      countReg     <= countNext;
      doneValidReg <= (stateNext == branch2_pkg::ST_DONE);
      if (issueValid && issueReady) begin
        issueReg <= issueData;
      end
      if (stateNext == branch2_pkg::ST_DONE) begin
        doneReg <= doneNext;
      end
    end
  end

endmodule // branch2_exec

// [verilog/branch2_cfg.svh]
// constants for the compare, loop, trap and return execution block
// Summary of operation
// - byte compare of the low accumulator with imm8 sets N Z V C, branches when unequal, 5 cycles taken and 4 not.
// - word compare of the accumulator with imm16 sets N Z V C, branches when unequal, and is 4 bytes long.
// - byte compare with a register operand takes 13 cycles taken and 12 not.
// - word compare with a register operand takes 8 cycles taken and 7 not.
// - compare with a memory operand takes 7 plus addressing cycles taken and 6 plus addressing not.
// - byte decrement writes back operand minus one, sets N Z V, keeps C, branches when nonzero.
// - word decrement writes back operand minus one, sets N Z V, keeps C, branches when nonzero.
// - decrement-and-branch on a register takes 7 cycles taken and 6 not.
// - decrement-and-branch on memory is a locked read-modify-write of 8 plus addressing taken, 7 plus not.
// - software traps take 20 (vector), 16 (addr16), 17 (addr24) and 20 (single byte) cycles.
// - trap return reloads all state and flags from the stack with six word reads in 15 cycles; the code reloads only program counter, bank and flags.
// - frame setup pushes the old frame pointer, loads the new one, reserves imm8 bytes, 6 cycles, no flags.
// - frame teardown restores the old frame pointer from the stack in 5 cycles, one byte, no flags.
// - near return pops one word into the program counter in 4 cycles with no flag change.
// - far return pops a long word into program counter and bank in 6 cycles.
`ifndef BRANCH2_CFG_SVH
`define BRANCH2_CFG_SVH

`define CYC_CBA_TAKEN    9'h005
`define CYC_CBA_NOT      9'h004
`define CYC_CBR_TAKEN    9'h00D
`define CYC_CBR_NOT      9'h00C
`define CYC_CWR_TAKEN    9'h008
`define CYC_CWR_NOT      9'h007
`define CYC_CBM_TAKEN    9'h007
`define CYC_CBM_NOT      9'h006
`define CYC_DBR_TAKEN    9'h007
`define CYC_DBR_NOT      9'h006
`define CYC_DBM_TAKEN    9'h008
`define CYC_DBM_NOT      9'h007
`define CYC_TRAP_VEC     9'h014
`define CYC_TRAP_A16     9'h010
`define CYC_TRAP_A24     9'h011
`define CYC_TRAP_SHORT   9'h014
`define CYC_TRAP_RET     9'h00F
`define CYC_FRAME_SET    9'h006
`define CYC_FRAME_DOWN   9'h005
`define CYC_RET_NEAR     9'h004
`define CYC_RET_FAR      9'h006
`define LEN_CMP_WORD_ACC 3'h4
`define TRAP_RET_WORDS   3'h6
`define FLAG_N           3
`define FLAG_Z           2
`define FLAG_V           1
`define FLAG_C           0

`endif

// [verilog/branch2_pkg.sv]
// types for the compare, loop, trap and return execution block
package branch2_pkg;

  typedef enum logic [3:0] {
    OP_CMP_ACC     = 4'h0,
    OP_CMP_REG     = 4'h1,
    OP_CMP_MEM     = 4'h2,
    OP_DEC_REG     = 4'h3,
    OP_DEC_MEM     = 4'h4,
    OP_TRAP_VEC    = 4'h5,
    OP_TRAP_A16    = 4'h6,
    OP_TRAP_A24    = 4'h7,
    OP_TRAP_SHORT  = 4'h8,
    OP_TRAP_RET    = 4'h9,
    OP_FRAME_SET   = 4'hA,
    OP_FRAME_DOWN  = 4'hB,
    OP_RET_NEAR    = 4'hC,
    OP_RET_FAR     = 4'hD
  } op_t;

  typedef struct packed {
    op_t         op;
    logic        isWord;
    logic [15:0] operand;
    logic [15:0] immediate;
    logic [7:0]  disp;
    logic [15:0] nextPc;
    logic [7:0]  addrCycles;
    logic [15:0] trapPc;
    logic [7:0]  trapBank;
  } issue_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  bank;
    logic        pcLoad;
    logic        bankLoad;
    logic [3:0]  flags;
    logic        flagsLoad;
    logic [15:0] result;
    logic        resultWrite;
    logic        busLock;
    logic [15:0] frameSp;
    logic        frameLoad;
  } done_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } state_t;

endpackage

// [bench/branch2_exec_checker.sv]
// assertion checker for the branch2 execution sequencer
`timescale 1ns/1ps
module branch2_exec_checker (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                resetn,
  // issue and completion
  input wire logic                issueValid,
  input wire logic                issueReady,
  input wire branch2_pkg::issue_t issueData,
  input wire logic                doneValid,
  input wire branch2_pkg::done_t  doneData,
  input wire logic                busy
);
  // ========================================
  // taken issue and its operation
  default clocking dcb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic             go = issueValid && issueReady;
  wire branch2_pkg::op_t op = issueData.op;
  // ========================================
  // handshake and timing
  AST_TAKE_BUSY:
    assert property (go |=> busy && !issueReady) else $error("not busy");
  AST_DONE_PULSE:
    assert property (doneValid |=> !doneValid) else $error("long done");
  AST_DONE_REFUSE:
    assert property (doneValid |-> !issueReady) else $error("ready at done");
  AST_CMP_ACC:
    assert property (go && op == branch2_pkg::OP_CMP_ACC |-> ##[4:5]
      doneValid) else $error("compare timing");
  AST_DEC_REG:
    assert property (go && op == branch2_pkg::OP_DEC_REG |-> ##[6:7]
      (doneValid && doneData.resultWrite && !doneData.busLock))
      else $error("decrement timing");
  AST_DEC_MEM:
    assert property (go && op == branch2_pkg::OP_DEC_MEM |-> ##[7:263]
      (doneValid && doneData.busLock)) else $error("no locked write");
  AST_TRAP_RET:
    assert property (go && op == branch2_pkg::OP_TRAP_RET |-> ##15
      (doneValid && doneData.flagsLoad)) else $error("trap return");
  AST_FRAME_DOWN:
    assert property (go && op == branch2_pkg::OP_FRAME_DOWN |-> ##5
      (doneValid && !doneData.flagsLoad)) else $error("frame teardown");
  AST_RET_NEAR:
    assert property (go && op == branch2_pkg::OP_RET_NEAR |=> !doneValid[*3]
      ##1 (doneValid && doneData.pcLoad)) else $error("near return");
  AST_RET_FAR:
    assert property (go && op == branch2_pkg::OP_RET_FAR |-> ##6
      (doneValid && doneData.bankLoad)) else $error("far return");
endmodule // branch2_exec_checker

bind branch2_exec branch2_exec_checker u_branch2_exec_checker (
  .clk_sys(clk_sys), .resetn(resetn), .issueValid(issueValid),
  .issueReady(issueReady), .issueData(issueData), .doneValid(doneValid),
  .doneData(doneData), .busy(busy));

// [bench/tb_branch2_exec.sv]
// self-checking testbench for the branch2 execution sequencer
`timescale 1ns/1ps
module tb_branch2_exec;
  logic                clk_sys    = 1'b0;
  logic                resetn     = 1'b0;
  logic                issueValid = 1'b0;
  branch2_pkg::issue_t issueData  = '0;
  logic [3:0]          flagsIn    = 4'h0;
  logic [15:0]         stackWord0 = 16'h0000;
  logic [15:0]         stackWord1 = 16'h0000;
  logic [15:0]         framePtr   = 16'h0000;
  logic [15:0]         stackPtr   = 16'h0000;
  logic                issueReady;
  logic                doneValid;
  logic                busy;
  branch2_pkg::done_t  doneData;
  logic [2:0]          stackWords;
  int                  badCount   = 0;
  int                  checks     = 0;
  logic [15:0]         opv[3]     = '{16'h0001, 16'h8000, 16'h0080};
  logic [15:0]         imv[3]     = '{16'h0001, 16'hFF01, 16'h0080};
  int                  cyT[14] = '{5,13,7,7,8,20,16,17,20,15,6,5,4,6};
  int                  cyN[14] = '{4,12,6,6,7,20,16,17,20,15,6,5,4,6};

  always #5 clk_sys = ~clk_sys;

  branch2_exec u_branch2_exec (.clk_sys(clk_sys), .resetn(resetn),
    .issueValid(issueValid), .issueReady(issueReady),
    .issueData(issueData), .flagsIn(flagsIn), .stackWord0(stackWord0),
    .stackWord1(stackWord1), .framePtr(framePtr), .stackPtr(stackPtr),
    .doneValid(doneValid), .doneData(doneData), .busy(busy),
    .stackWords(stackWords));

  // ========================================
  // reporting
  task automatic stopTest;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic hang;
    chk("handshake", 1, 0);
    stopTest();
  endtask

  // ========================================
  // expectations
  function automatic logic [15:0] mask(logic w, logic [15:0] v);
    return w ? v : {8'h00, v[7:0]};
  endfunction

  function automatic int expCyc(branch2_pkg::issue_t d, logic t);
    int n;
    n = t ? cyT[d.op] : cyN[d.op];
    if (d.op == branch2_pkg::OP_CMP_REG && d.isWord) n = t ? 8 : 7;
    if (d.op == branch2_pkg::OP_CMP_MEM || d.op == branch2_pkg::OP_DEC_MEM)
      n += d.addrCycles;
    return n;
  endfunction

  function automatic branch2_pkg::issue_t rndIssue(int o);
    branch2_pkg::issue_t d;
    d = 93'({$urandom, $urandom, $urandom});
    d.op = branch2_pkg::op_t'(o);
    // no addressing-mode field, so no post-increment form
    // small address overhead keeps memory forms short
    d.addrCycles = {6'h00, d.addrCycles[1:0]};
    return d;
  endfunction

  // ========================================
  // one instruction, held valid one cycle into busy to be refused
  task automatic run(branch2_pkg::issue_t d);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] r;
    logic        tk;
    logic        dec;
    int          n;
    int          m;
    int          e;
    n = 0;
    while (issueReady !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50) hang();
    {stackWord0, stackWord1, framePtr, stackPtr} = {$urandom, $urandom};
    flagsIn    = 4'($urandom);
    issueData  = d;
    issueValid = 1'b1;
    @(negedge clk_sys);
    chk("busy", 2'b10, {busy, issueReady});
    chk("stackWords", d.op == branch2_pkg::OP_TRAP_RET ? 6 : 0,
      stackWords);
    // a request while busy must leave the held one untouched
    issueData.operand = ~d.operand;
    issueData.nextPc  = ~d.nextPc;
    @(negedge clk_sys);
    issueValid = 1'b0;
    n = 2;
    while (doneValid !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 300) hang();
    chk("readyDone", 0, issueReady);
    dec = d.op == branch2_pkg::OP_DEC_REG || d.op == branch2_pkg::OP_DEC_MEM;
    m = d.isWord ? 15 : 7;
    a = mask(d.isWord, d.operand);
    b = dec ? 16'h0001 : mask(d.isWord, d.immediate);
    r = mask(d.isWord, a - b);
    tk = r != 16'h0000;
    e = expCyc(d, tk);
    if (d.op < 3) chk("cyc", e, n);
    else if (d.op < 5) chk("cyc", e, n);
    else if (d.op < 9) chk("cyc", e, n);
    else chk("cyc", e, n);
    if (d.op < 5) begin
      chk("flags", {1'b1, r[m], !tk, (a[m] ^ b[m]) & (a[m] ^ r[m]),
        dec ? flagsIn[0] : a < b},
        {doneData.flagsLoad, doneData.flags});
      if (tk) chk("target", {1'b1, d.nextPc + {{8{d.disp[7]}}, d.disp}},
        {doneData.pcLoad, doneData.pc});
      else chk("fallPc", {1'b1, d.nextPc},
        {doneData.pcLoad, doneData.pc});
      if (dec) chk("result", {1'b1, d.op == branch2_pkg::OP_DEC_MEM, r},
        {doneData.resultWrite, doneData.busLock,
        mask(d.isWord, doneData.result)});
    end else begin
      case (d.op)
        branch2_pkg::OP_TRAP_RET: chk("trapRet", {3'h7, stackWord0,
          stackWord1[7:0], stackWord1[11:8]}, {doneData.pcLoad,
          doneData.bankLoad, doneData.flagsLoad, doneData.pc,
          doneData.bank, doneData.flags});
        branch2_pkg::OP_FRAME_SET: chk("frame", {2'b10, stackPtr -
          {8'h00, d.immediate[7:0]}}, {doneData.frameLoad,
          doneData.flagsLoad, doneData.frameSp});
        branch2_pkg::OP_FRAME_DOWN: begin
          chk("frameDown", {2'b10, stackWord0}, {doneData.frameLoad,
            doneData.flagsLoad, doneData.result});
          chk("frameSp", framePtr, doneData.frameSp);
        end
        branch2_pkg::OP_RET_NEAR: chk("retNear", {2'b10, stackWord0},
          {doneData.pcLoad, doneData.flagsLoad, doneData.pc});
        branch2_pkg::OP_RET_FAR: chk("retFar", {2'b11, stackWord0,
          stackWord1[7:0]}, {doneData.pcLoad, doneData.bankLoad,
          doneData.pc, doneData.bank});
        default: chk("trapPc", {2'b11, d.trapPc, d.trapBank},
          {doneData.pcLoad, doneData.bankLoad, doneData.pc,
          doneData.bank});
      endcase
    end
  endtask

  // ========================================
  // main sequence
  initial begin
    branch2_pkg::issue_t d;
    void'($urandom(32'hA070));
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    chk("resetOut", 3'b100, {issueReady, busy, doneValid});
    chk("resetData", 1, doneData === '0);
    $display("test reset done");
    // equal, most negative and sign-boundary operands on every operation
    for (int o = 0; o < 14; o++)
      for (int w = 0; w < 2; w++)
        for (int k = 0; k < 3; k++) begin
          d = rndIssue(o);
          d.isWord = w[0];
          d.operand = opv[k];
          d.immediate = imv[k];
          d.disp = 8'h80;
          run(d);
        end
    // longest addressing overhead on both memory forms
    for (int o = 2; o < 5; o += 2) begin
      d = rndIssue(o);
      d.addrCycles = 8'hFF;
      run(d);
    end
    $display("test corners done");
    for (int i = 0; i < 150; i++)
      run(rndIssue($urandom % 14));
    $display("test random done");
    stopTest();
  end
endmodule // tb_branch2_exec
